// >>> src/dtc_pkg.sv
// Shared constants and types for the transfer controller register view.
package dtc_pkg;

	// Number of destination slot register sets.
	localparam int DST_SET_DEPTH = 4;

	// Register byte offsets on the AXI4-Lite bus.
	localparam logic [7:0] OFF_SRC_ARRAY_BASE_REF     = 8'h00;
	localparam logic [7:0] OFF_SRC_SET_DST_BASE_REF   = 8'h04;
	localparam logic [7:0] OFF_ARRAY_COUNT_RELOAD     = 8'h08;
	localparam logic [7:0] OFF_ARRAY_BYTE_COUNT       = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS             = 8'h10;
	localparam logic [7:0] OFF_IRQ_ENABLE             = 8'h14;
	localparam logic [7:0] OFF_IRQ_CLEAR              = 8'h18;
	localparam logic [7:0] OFF_DST_SLOT_BASE          = 8'h40;
	localparam logic [7:0] OFF_DST_SLOT_STRIDE        = 8'h08;
	localparam logic [7:0] OFF_DST_SLOT_SRC_ADDR      = 8'h04;

	// Options word field positions.
	localparam int OPT_CHAIN_EN_BIT  = 22;
	localparam int OPT_IRQ_EN_BIT    = 20;
	localparam int OPT_CODE_LSB      = 12;
	localparam int OPT_CODE_MSB      = 17;
	localparam int OPT_WIDTH_LSB     = 8;
	localparam int OPT_WIDTH_MSB     = 10;
	localparam int OPT_PRIO_LSB      = 4;
	localparam int OPT_PRIO_MSB      = 6;
	localparam int OPT_DST_MODE_BIT  = 1;
	localparam int OPT_SRC_MODE_BIT  = 0;

	// Writable bits of the options word; all others are reserved.
	localparam logic [31:0] OPT_WMASK = 32'h0053F773;

	// Highest legal FIFO width selection (256 bits).
	localparam logic [2:0] FIFO_WIDTH_MAX_SEL = 3'h5;

	// Reset values.
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [2:0]  RST_IRQ  = 3'h0;

	// Interrupt status bit positions.
	localparam int IRQ_DONE_BIT      = 0;
	localparam int IRQ_ACCEPT_BIT    = 1;
	localparam int IRQ_BAD_WIDTH_BIT = 2;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Transfer request submitted by the channel controller.
	typedef struct packed {
		logic [31:0] options;
		logic [31:0] src_addr;
		logic [31:0] dst_addr;
		logic [15:0] array_byte_count;
		logic [15:0] array_count;
		logic [15:0] src_bidx;
		logic [15:0] dst_bidx;
	} dtc_tr_s;

	// One byte moved: source read address and destination write address.
	typedef struct packed {
		logic [31:0] src;
		logic [31:0] dst;
	} dtc_beat_s;

	// Engine states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RUN  = 3'b010,
		ST_DONE = 3'b100
	} dtc_state_e;

endpackage

// >>> src/dtc_slot_arb.sv
// Priority picker over the destination slots and free-slot finder.
`timescale 1ns/1ps
module dtc_slot_arb (
	input  wire logic [dtc_pkg::DST_SET_DEPTH-1:0]   busy,     // Slot holds a pending request.
	input  wire logic [3*dtc_pkg::DST_SET_DEPTH-1:0] prio,     // Three-bit priority per slot.
	output logic                                     grant_ok, // Some slot is pending.
	output logic [1:0]                               grant,    // Pending slot to start.
	output logic                                     free_ok,  // Some slot is free.
	output logic [1:0]                               free      // Lowest free slot.
);

	// Lowest priority value wins; ties go to the lower slot index so that
	// equal-priority requests are served in slot order.
	always_comb begin
		logic [2:0] best;
		best     = 3'h7;
		grant_ok = 1'b0;
		grant    = 2'h0;
		free_ok  = 1'b0;
		free     = 2'h0;
		for (int i = dtc_pkg::DST_SET_DEPTH - 1; i >= 0; i--) begin
			if (busy[i] && (!grant_ok || prio[3*i +: 3] <= best)) begin
				grant_ok = 1'b1;
				grant    = 2'(i);
				best     = prio[3*i +: 3];
			end
			if (!busy[i]) begin
				free_ok = 1'b1;
				free    = 2'(i);
			end
		end
	end

endmodule

// >>> src/dtc_regs.sv
// Transfer controller: request slots, byte engine and AXI4-Lite register view.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// [R01] - The source array base register is read only, shows the start of the array being read, and resets to zero.
// [R02] - There is one destination slot register set per slot, indexed from zero to one less than the slot depth.
// [R03] - Options bit 22 enables completion chaining when set.
// [R04] - Options bit 20 enables the completion interrupt when set.
// [R05] - Options bits 17 to 12 hold a 6-bit code that picks the bit to set in the chain or interrupt pending vector on completion.
// [R06] - Options bits 10 to 8 select a FIFO width of 8 to 256 bits for values 0 to 5, with 6 and 7 reserved.
// [R07] - The FIFO width matters only when the source or destination address mode is constant.
// [R08] - Options bits 6 to 4 give the priority, 0 highest and 7 lowest.
// [R09] - Options bit 1 makes destination addressing increment at 0 or stay constant and wrap at the FIFO width at 1.
// [R10] - Options bit 0 makes source addressing increment at 0 or stay constant and wrap at the FIFO width at 1.
// [R11] - The destination base reference and each slot source address word read zero, as do reserved option bits.
// [R12] - The count reload value keeps the programmed array byte count and refills the active count after each array but the last.
module dtc_regs (
	input  wire logic              clk,              // Clock, 100 MHz.
	input  wire logic              rst,              // Asynchronous reset, active high.
	input  wire logic [7:0]        s_axi_awaddr,     // Write address.
	input  wire logic              s_axi_awvalid,    // Write address valid.
	output logic                   s_axi_awready,    // Write address ready.
	input  wire logic [31:0]       s_axi_wdata,      // Write data.
	input  wire logic [3:0]        s_axi_wstrb,      // Write byte strobes.
	input  wire logic              s_axi_wvalid,     // Write data valid.
	output logic                   s_axi_wready,     // Write data ready.
	output logic [1:0]             s_axi_bresp,      // Write response.
	output logic                   s_axi_bvalid,     // Write response valid.
	input  wire logic              s_axi_bready,     // Write response ready.
	input  wire logic [7:0]        s_axi_araddr,     // Read address.
	input  wire logic              s_axi_arvalid,    // Read address valid.
	output logic                   s_axi_arready,    // Read address ready.
	output logic [31:0]            s_axi_rdata,      // Read data.
	output logic [1:0]             s_axi_rresp,      // Read response.
	output logic                   s_axi_rvalid,     // Read data valid.
	input  wire logic              s_axi_rready,     // Read data ready.
	input  wire logic              tr_valid,         // Transfer request offered.
	output logic                   tr_ready,         // A slot is free.
	input  wire dtc_pkg::dtc_tr_s  tr,               // Transfer request payload.
	output logic                   beat_valid,       // Byte move offered.
	input  wire logic              beat_ready,       // Byte move taken.
	output dtc_pkg::dtc_beat_s     beat,             // Byte move addresses.
	output logic [63:0]            chain_event_set,  // One-cycle chained event set.
	output logic [63:0]            irq_pend_set,     // One-cycle interrupt pending set.
	output logic                   irq               // Level interrupt.
);

	localparam int N = dtc_pkg::DST_SET_DEPTH;

	////////////////////////////////////////////////////////////////////////////
	// Slot storage.

	dtc_pkg::dtc_tr_s     slot [N];
	logic [N-1:0]         slot_busy;
	logic [3*N-1:0]       slot_prio;
	logic                 grant_ok;
	logic [1:0]           grant;
	logic                 free_ok;
	logic [1:0]           free;

	// Active transfer state.
	dtc_pkg::dtc_state_e  state;
	logic [31:0]          act_opt;
	logic [31:0]          src_array_base_addr;
	logic [31:0]          dst_array_base_addr;
	logic [15:0]          array_count_reload;
	logic [15:0]          array_byte_count;
	logic [15:0]          array_count;
	logic [15:0]          src_bidx;
	logic [15:0]          dst_bidx;
	logic [7:0]           src_off;
	logic [7:0]           dst_off;

	// Bus state.
	logic                 aw_held;
	logic                 w_held;
	logic [7:0]           aw_addr;
	logic [31:0]          w_data;
	logic [3:0]           w_strb;
	logic [2:0]           irq_status;
	logic [2:0]           irq_enable;

	dtc_slot_arb u_arb (
		.busy     (slot_busy),
		.prio     (slot_prio),
		.grant_ok (grant_ok),
		.grant    (grant),
		.free_ok  (free_ok),
		.free     (free)
	);

	////////////////////////////////////////////////////////////////////////////
	// Option decode of the active transfer.

	wire        src_const  = act_opt[dtc_pkg::OPT_SRC_MODE_BIT];
	wire        dst_const  = act_opt[dtc_pkg::OPT_DST_MODE_BIT];
	wire [2:0]  width_sel  = act_opt[dtc_pkg::OPT_WIDTH_MSB:dtc_pkg::OPT_WIDTH_LSB];
	wire [5:0]  code       = act_opt[dtc_pkg::OPT_CODE_MSB:dtc_pkg::OPT_CODE_LSB];
	wire        chain_en   = act_opt[dtc_pkg::OPT_CHAIN_EN_BIT];
	wire        cmpl_irqen = act_opt[dtc_pkg::OPT_IRQ_EN_BIT];

	// Reserved widths fall back to 8 bits so a bad setting never wraps past a
	// real FIFO; with a constant mode set, the bad setting is flagged as an interrupt event.
	wire        width_ok   = width_sel <= dtc_pkg::FIFO_WIDTH_MAX_SEL; // [R06]
	wire [7:0]  fifo_bytes = width_ok ? (8'h01 << width_sel) : 8'h01;  // [R06]
	wire [7:0]  wrap_mask  = fifo_bytes - 8'h01;

	// Each beat moves one byte; constant mode wraps the offset at the FIFO
	// width, otherwise the width selection is ignored.
	wire [7:0]  src_off_inc = src_off + 8'h01;
	wire [7:0]  dst_off_inc = dst_off + 8'h01;
	wire [7:0]  next_src_off = src_const ? (src_off_inc & wrap_mask) : src_off_inc; // [R10] [R07]
	wire [7:0]  next_dst_off = dst_const ? (dst_off_inc & wrap_mask) : dst_off_inc; // [R09] [R07]

	wire        beat_fire  = beat_valid && beat_ready;
	wire        array_end  = beat_fire && (array_byte_count <= 16'h0001);
	wire        last_array = array_count <= 16'h0001;
	wire        tr_fire    = tr_valid && tr_ready;
	wire        start      = (state == dtc_pkg::ST_IDLE) && grant_ok;
	wire [31:0] start_opt  = slot[grant].options;
	wire        start_bad  = start && (start_opt[dtc_pkg::OPT_SRC_MODE_BIT]
	                         || start_opt[dtc_pkg::OPT_DST_MODE_BIT])
	                         && (start_opt[dtc_pkg::OPT_WIDTH_MSB:dtc_pkg::OPT_WIDTH_LSB]
	                         > dtc_pkg::FIFO_WIDTH_MAX_SEL);

	assign tr_ready   = free_ok;
	assign beat_valid = state == dtc_pkg::ST_RUN;

	////////////////////////////////////////////////////////////////////////////
	// Register bus decode.

	wire        wr_go      = aw_held && w_held && !s_axi_bvalid;
	wire        rd_go      = s_axi_arvalid && !s_axi_rvalid;
	wire        wr_slot    = aw_addr >= dtc_pkg::OFF_DST_SLOT_BASE;
	wire [7:0]  wr_rel     = aw_addr - dtc_pkg::OFF_DST_SLOT_BASE;
	wire [1:0]  wr_idx     = wr_rel[4:3];
	wire        wr_opt     = wr_slot && (wr_rel < 8'(N * 8)) && (wr_rel[2:0] == 3'h0);
	wire        wr_slotsrc = wr_slot && (wr_rel < 8'(N * 8))
	                         && (wr_rel[2:0] == dtc_pkg::OFF_DST_SLOT_SRC_ADDR[2:0]);
	wire        wr_en_reg  = aw_addr == dtc_pkg::OFF_IRQ_ENABLE;
	wire        wr_clr_reg = aw_addr == dtc_pkg::OFF_IRQ_CLEAR;
	wire        wr_mapped  = wr_opt || wr_slotsrc || wr_en_reg || wr_clr_reg;
	wire [31:0] strb_mask  = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire [31:0] opt_wbits  = strb_mask & dtc_pkg::OPT_WMASK; // [R11]

	wire [7:0]  rd_rel     = s_axi_araddr - dtc_pkg::OFF_DST_SLOT_BASE;
	wire [1:0]  rd_idx     = rd_rel[4:3];
	wire        rd_slot    = (s_axi_araddr >= dtc_pkg::OFF_DST_SLOT_BASE)
	                         && (rd_rel < 8'(N * 8));
	logic [31:0] rd_word;
	logic        rd_hit;

	// Read selection; the zero-valued references still answer OKAY.
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		if (rd_slot && rd_rel[2:0] == 3'h0) begin
			rd_word = slot[rd_idx].options & dtc_pkg::OPT_WMASK; // [R02] [R11]
		end else if (rd_slot && rd_rel[2:0] == dtc_pkg::OFF_DST_SLOT_SRC_ADDR[2:0]) begin
			rd_word = 32'h00000000; // [R11]
		end else begin
			unique case (s_axi_araddr)
				dtc_pkg::OFF_SRC_ARRAY_BASE_REF:   rd_word = src_array_base_addr; // [R01]
				dtc_pkg::OFF_SRC_SET_DST_BASE_REF: rd_word = 32'h00000000;        // [R11]
				dtc_pkg::OFF_ARRAY_COUNT_RELOAD:   rd_word = {16'h0000, array_count_reload}; // [R12]
				dtc_pkg::OFF_ARRAY_BYTE_COUNT:     rd_word = {16'h0000, array_byte_count};
				dtc_pkg::OFF_IRQ_STATUS:           rd_word = {29'h0, irq_status};
				dtc_pkg::OFF_IRQ_ENABLE:           rd_word = {29'h0, irq_enable};
				dtc_pkg::OFF_IRQ_CLEAR:            rd_word = 32'h00000000;
				default:                           rd_hit  = 1'b0;
			endcase
		end
	end

	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign s_axi_arready = !s_axi_rvalid;

	////////////////////////////////////////////////////////////////////////////
	// Write channel: address and data are latched independently so either
	// may arrive first; the response waits for both.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= dtc_pkg::RST_WORD;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dtc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_mapped ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read channel answers one cycle after the address is taken.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= dtc_pkg::RST_WORD;
			s_axi_rresp  <= dtc_pkg::RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One register set per slot. A request load beats a software write in
	// the same cycle, since the request carries the authoritative options.

	for (genvar i = 0; i < N; i++) begin : g_slot
		wire load = tr_fire && free == 2'(i);
		wire sw   = wr_go && wr_opt && wr_idx == 2'(i);
		assign slot_prio[3*i +: 3] = slot[i].options[dtc_pkg::OPT_PRIO_MSB:dtc_pkg::OPT_PRIO_LSB]; // [R08]

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				slot[i]      <= '0;
				slot_busy[i] <= 1'b0;
			end else if (load) begin
				slot[i]      <= tr; // [R02]
				slot_busy[i] <= 1'b1;
			end else begin
				if (sw) begin
					slot[i].options <= (slot[i].options & ~opt_wbits) | (w_data & opt_wbits);
				end
				if (start && grant == 2'(i)) begin
					slot_busy[i] <= 1'b0; // [R08]
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte engine: walks each array a byte at a time; after each array but the last
	// it steps the array bases by their indices and refills the byte count from the reload.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state               <= dtc_pkg::ST_IDLE;
			act_opt             <= dtc_pkg::RST_WORD;
			src_array_base_addr <= dtc_pkg::RST_WORD; // [R01]
			dst_array_base_addr <= dtc_pkg::RST_WORD;
			array_count_reload  <= 16'h0000;
			array_byte_count    <= 16'h0000;
			array_count         <= 16'h0000;
			src_bidx            <= 16'h0000;
			dst_bidx            <= 16'h0000;
			src_off             <= 8'h00;
			dst_off             <= 8'h00;
		end else begin
			unique case (state)
				dtc_pkg::ST_IDLE: begin
					if (start) begin
						state               <= dtc_pkg::ST_RUN;
						act_opt             <= start_opt;
						src_array_base_addr <= slot[grant].src_addr; // [R01]
						dst_array_base_addr <= slot[grant].dst_addr;
						array_count_reload  <= slot[grant].array_byte_count; // [R12]
						array_byte_count    <= slot[grant].array_byte_count;
						array_count         <= slot[grant].array_count;
						src_bidx            <= slot[grant].src_bidx;
						dst_bidx            <= slot[grant].dst_bidx;
						src_off             <= 8'h00;
						dst_off             <= 8'h00;
					end
				end
				dtc_pkg::ST_RUN: begin
					if (array_end) begin
						src_off <= 8'h00;
						dst_off <= 8'h00;
						if (last_array) begin
							state <= dtc_pkg::ST_DONE;
						end else begin
							array_count         <= array_count - 16'h0001;
							array_byte_count    <= array_count_reload; // [R12]
							src_array_base_addr <= src_array_base_addr + {16'h0000, src_bidx};
							dst_array_base_addr <= dst_array_base_addr + {16'h0000, dst_bidx};
						end
					end else if (beat_fire) begin
						array_byte_count <= array_byte_count - 16'h0001;
						src_off          <= next_src_off; // [R10]
						dst_off          <= next_dst_off; // [R09]
					end
				end
				dtc_pkg::ST_DONE: begin
					state <= dtc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Beat addresses are registered copies of base plus offset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			beat <= '0;
		end else begin
			beat.src <= src_array_base_addr + {24'h000000, src_off};
			beat.dst <= dst_array_base_addr + {24'h000000, dst_off};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Completion: the code picks one of 64 bits, sent as a one-cycle pulse
	// toward the chain or pending vector of the channel controller.

	wire [63:0] code_bit = 64'h0000000000000001 << code; // [R05]

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			chain_event_set <= 64'h0000000000000000;
			irq_pend_set    <= 64'h0000000000000000;
		end else begin
			chain_event_set <= (array_end && last_array && chain_en) ? code_bit : 64'h0; // [R03]
			irq_pend_set    <= (array_end && last_array && cmpl_irqen) ? code_bit : 64'h0; // [R04]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Local interrupts: sticky status, set beats clear in the same cycle.

	wire [2:0] irq_events = {start_bad, tr_fire, state == dtc_pkg::ST_DONE};
	wire [2:0] irq_clear  = (wr_go && wr_clr_reg) ? w_data[2:0] & {3{w_strb[0]}} : 3'h0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_status <= dtc_pkg::RST_IRQ;
			irq_enable <= dtc_pkg::RST_IRQ;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
			if (wr_go && wr_en_reg && w_strb[0]) begin
				irq_enable <= w_data[2:0];
			end
		end
	end

	assign irq = |(irq_status & irq_enable);

endmodule

// >>> verif/dtc_regs_assertions.sv
// Port checks for the transfer controller register view.
`timescale 1ns/1ps
module dtc_regs_checker (
	input wire logic        clk,             // Clock.
	input wire logic        rst,             // Reset.
	input wire logic        s_axi_arvalid,   // Read address valid.
	input wire logic        s_axi_arready,   // Read address ready.
	input wire logic [31:0] s_axi_rdata,     // Read data.
	input wire logic        s_axi_rvalid,    // Read valid.
	input wire logic        s_axi_rready,    // Read ready.
	input wire logic [1:0]  s_axi_bresp,     // Write response.
	input wire logic        s_axi_bvalid,    // Response valid.
	input wire logic        s_axi_bready,    // Response ready.
	input wire logic        beat_valid,      // Move offered.
	input wire logic        beat_ready,      // Move taken.
	input wire logic [63:0] chain_event_set, // Chain pulse.
	input wire logic [63:0] irq_pend_set     // Pending pulse.
);
	////////////////////////////////////////
	// All checks share the one clock, and reset silences them.
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("second read taken");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_chain_onehot: assert property (|chain_event_set |-> $onehot(chain_event_set))
		else $error("chain set not one bit");
	a_pend_pulse: assert property (|irq_pend_set |=> irq_pend_set == '0)
		else $error("pending set longer than a cycle");
	a_chain_late: assert property (|chain_event_set |-> $past(beat_valid && beat_ready))
		else $error("chain set not after last move");
	a_move_wait: assert property (beat_valid && !beat_ready |=> beat_valid)
		else $error("move withdrawn");
	cover property (|chain_event_set);
	cover property (s_axi_rvalid && !s_axi_rready);
	cover property (beat_valid && beat_ready);
endmodule
bind dtc_regs dtc_regs_checker dtc_regs_checker_i (.*);

// >>> verif/dtc_chan_model.sv
// Channel controller model: offers requests and takes byte moves.
`timescale 1ns/1ps
module dtc_chan_model (
	input  wire logic             clk,        // Clock.
	input  wire logic             rst,        // Reset.
	input  wire logic             send,       // Offer req.
	input  wire dtc_pkg::dtc_tr_s req,        // Request.
	output logic                  tr_valid,   // Offered.
	input  wire logic             tr_ready,   // Slot free.
	output dtc_pkg::dtc_tr_s      tr,         // Payload.
	input  wire logic             beat_valid, // Move offered.
	output logic                  beat_ready  // Move taken.
);
	////////////////////////////////////////
	// The offer stands until taken; then the payload is inverted so stale data never passes.
	// Ready rises a cycle after a move shows and drops after each take, like a slow memory.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tr_valid <= 1'b0;
			tr <= '0;
			beat_ready <= 1'b0;
		end else begin
			if (send) begin
				tr_valid <= 1'b1;
				tr <= req;
			end else if (tr_valid && tr_ready) begin
				tr_valid <= 1'b0;
				tr <= ~tr;
			end
			beat_ready <= beat_valid && !beat_ready;
		end
	end
endmodule

// >>> verif/dtc_regs_bench.sv
// Self-checking bench for the transfer controller register view.
`timescale 1ns/1ps
module dtc_regs_bench;
	logic               clk = 1'b0;
	logic               rst;
	logic [7:0]         s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]        s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]         s_axi_wstrb = 4'hF;
	logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, send = 1'b0;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic               tr_valid, tr_ready, beat_valid, beat_ready, irq;
	logic [63:0]        chain_event_set, irq_pend_set, chain_seen, pend_seen;
	dtc_pkg::dtc_tr_s   tr, req = '0;
	dtc_pkg::dtc_beat_s beat, lg [8];
	int                 nb, checks = 0, err_count = 0;

	always #5 clk = ~clk;
	dtc_regs dtc_regs_i (.*);
	dtc_chan_model dtc_chan_model_i (.*);

	////////////////////////////////////////
	// Log taken moves and gather completion pulses; a new offer clears the log.
	always @(posedge clk) begin
		if (send) begin
			nb <= 0;
			chain_seen <= '0;
			pend_seen <= '0;
		end else begin
			if (beat_valid && beat_ready) begin
				lg[nb[2:0]] <= beat;
				nb <= nb + 1;
			end
			chain_seen <= chain_seen | chain_event_set;
			pend_seen <= pend_seen | irq_pend_set;
		end
	end

	task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
		checks++;
		if (s !== x) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, x, s);
		end
	endtask

	// Response ready goes up with the request and stays until the answer is sampled.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, e);
		chk("timeout", n == 50, 1'b0);
		if (n == 50) results();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, d);
		chk("rresp", s_axi_rresp, e);
		chk("timeout", n == 50, 1'b0);
		if (n == 50) results();
	endtask

	// Two arrays of c bytes, bases stepped by 10h and 20h; constant modes wrap at the FIFO width.
	task automatic xfer(input logic [31:0] o, input logic [15:0] c);
		int n;
		int w;
		w = (o[10:8] > 3'h5) ? 1 : (1 << o[10:8]);
		@(posedge clk);
		req <= '{o, 32'h1000, 32'h2000, c, 16'h2, 16'h10, 16'h20};
		send <= 1'b1;
		@(posedge clk);
		send <= 1'b0;
		for (n = 0; n < 99 && nb != 2 * int'(c); n++) @(posedge clk);
		repeat (3) @(posedge clk);
		chk("beats", nb, 2 * c);
		for (int i = 0; i < 2 * c; i++) begin
			int j;
			j = i % c;
			chk("src", lg[i].src, 32'h1000 + 16 * (i / c) + (o[0] ? j % w : j));
			chk("dst", lg[i].dst, 32'h2000 + 32 * (i / c) + (o[1] ? j % w : j));
		end
		chk("timeout", n == 99, 1'b0);
		if (n == 99) results();
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		rst = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) rd(8'(4 * i), '0);
		for (int i = 0; i < 8; i++) rd(8'h40 + 8'(4 * i), '0);
		$display("test reset values done");
		// Only writable option bits stick; the slot source word and unmapped places stay dead.
		for (int i = 0; i < 4; i++) begin
			wr(8'h40 + 8'(8 * i), 32'hFFFFFFFF);
			rd(8'h40 + 8'(8 * i), 32'h0053F773);
			wr(8'h44 + 8'(8 * i), 32'hFFFFFFFF);
			rd(8'h44 + 8'(8 * i), '0);
		end
		// A strobed write touches only its byte lane of the options word.
		s_axi_wstrb <= 4'h2;
		wr(8'h40, '0);
		s_axi_wstrb <= 4'hF;
		rd(8'h40, 32'h00530073);
		wr(8'h3C, 32'hFFFFFFFF, 2'h2);
		rd(8'h3C, '0, 2'h2);
		$display("test option masks done");
		// Every code, width, priority and mode value reads back as written.
		for (int i = 0; i < 64; i++) begin
			logic [31:0] o;
			o = {9'h0, i[0], 1'b0, i[1], 2'h0, i[5:0], 1'b0, i[2:0], 1'b0, i[5:3], 2'h0, i[1:0]};
			wr(8'h40 + 8'(8 * (i % 4)), o);
			rd(8'h40 + 8'(8 * (i % 4)), o);
		end
		$display("test option fields done");
		// Chained, interrupting transfer into a 16-bit constant destination.
		wr(8'h14, 32'h7);
		xfer(32'h0052A132, 16'h4);
		chk("chain", chain_seen, 64'h1 << 42);
		chk("pend", pend_seen, 64'h1 << 42);
		chk("irq", irq, 1'b1);
		rd(8'h40, 32'h0052A132);
		rd(8'h00, 32'h1010);
		rd(8'h04, '0);
		rd(8'h08, 32'h4);
		rd(8'h10, 32'h3);
		wr(8'h14, '0);
		chk("irq", irq, 1'b0);
		wr(8'h18, 32'h7);
		rd(8'h10, '0);
		$display("test transfer done");
		// Reserved width with a constant source: byte wrap, chain only, bad width flagged.
		xfer(32'h0043F601, 16'h3);
		chk("chain", chain_seen, 64'h1 << 63);
		chk("pend", pend_seen, '0);
		rd(8'h10, 32'h7);
		chk("irq", irq, 1'b0);
		wr(8'h14, 32'h4);
		chk("irq", irq, 1'b1);
		$display("test reserved width done");
		results();
	end
endmodule
